// ### rtl/endian_swap_pkg.sv
// Constants and types for the endian steering bridge.
// Assumes one 125 MHz clock and an active-low asynchronous reset.
// Function
// - Steering sits on the translation-unit path and on the host-port path.
// - When enabled, writes convert big to little and reads little to big.
// - A bypass lets data pass unchanged when swapping is off.
// - Little-endian byte 0 in bits 7:0; big-endian byte 0 in 31:24.
// - Ordinary DSP writes reverse all four bytes.
// - Ordinary DSP reads reverse all four bytes.
// - Odd-halfword or halfword-mode-low 32-bit writes exchange the two halves.
// - Odd-halfword or halfword-mode-low 32-bit reads exchange the two halves.
// - Halfword format carries bytes 1,0,3,2 from bit 31 downward.
// - Byte and 16-bit accesses are right-justified in the low lanes.
// - Translation-unit path swapping is disabled after power-up.
// - Width is decoded and lanes repacked for byte, halfword and word.
// - Host-port swap settings kept apart for memory and non-memory regions.
// - Host-port 32-bit accesses run as two 16-bit transfers.
// - Host-port halfword exchange and byte reversal programmed independently; only byte reversal alters port data.
// - Host-port byte reversal is disabled after reset for all regions.
// - Host-port halfword exchange is enabled after reset for all regions.
package endian_swap_pkg;
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_RSVD} access_size_t;

    // Register map on the plain configuration port
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int CTRL_DSP_EN     = 0;
    localparam int CTRL_MEM_BYTE   = 1;
    localparam int CTRL_MEM_HALF   = 2;
    localparam int CTRL_REG_BYTE   = 3;
    localparam int CTRL_REG_HALF   = 4;
    localparam logic [4:0] CTRL_RESET = 5'h14;
    localparam logic [1:0] HALF_LO = 2'h0;
    localparam logic [1:0] HALF_HI = 2'h1;
endpackage : endian_swap_pkg

// ### rtl/endian_swap_steering.sv
// Endian steering for the DSP translation-unit path and the host port path.
// Assumes all requests are synchronous to clk; partners honour valid/ready.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module endian_swap_steering (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    // Configuration port
    input  wire logic [3:0]                    cfgAddr,
    input  wire logic [31:0]                   cfgWdata,
    input  wire logic                          cfgWrite,
    input  wire logic                          cfgRead,
    output var  logic [31:0]                   cfgRdata,
    // DSP side of the translation-unit path
    input  wire logic                          dspValid,
    output var  logic                          dspReady,
    input  wire logic                          dspWrite,
    input  wire endian_swap_pkg::access_size_t dspSize,
    input  wire logic                          dspOddHalf,
    input  wire logic                          dspByteNword,
    input  wire logic [31:0]                   dspWdata,
    output var  logic                          dspRvalid,
    output var  logic [31:0]                   dspRdata,
    // Memory side of the translation-unit path
    output var  logic                          memValid,
    input  wire logic                          memReady,
    output var  logic                          memWrite,
    output var  logic [1:0]                    memSize,
    output var  logic [31:0]                   memWdata,
    input  wire logic                          memRvalid,
    input  wire logic [31:0]                   memRdata,
    // Host port: one 16-bit transfer per beat
    input  wire logic                          hostValid,
    output var  logic                          hostReady,
    input  wire logic                          hostWrite,
    input  wire logic                          hostMemRegion,
    input  wire logic                          hostWide,
    input  wire logic                          hostUpper,
    input  wire logic [15:0]                   hostWdata,
    output var  logic [15:0]                   hostRdata,
    // DSP side of the host port path
    output var  logic                          dspPortValid,
    input  wire logic                          dspPortReady,
    output var  logic                          dspPortWrite,
    output var  logic [15:0]                   dspPortWdata,
    input  wire logic [15:0]                   dspPortRdata
);
    import endian_swap_pkg::*;

    typedef struct packed {
        logic        write;
        logic [1:0]  size;
        logic [31:0] data;
    } entry_t;

    typedef struct packed {
        logic [4:0]  ctrl;
        logic [31:0] cfgRdata;
        entry_t      e0;
        entry_t      e1;
        logic        v0;
        logic        v1;
        logic        rdValid;
        logic [31:0] rdData;
        logic [15:0] hostRdata;
        logic        hostUpperSeen;
        logic [15:0] hostHeld;
    } state_t;

    state_t cur;
    state_t next_cur;

    // Byte reverse, halfword exchange, or pass: shared by both directions
    function automatic logic [31:0] steer32(input logic en, input logic [1:0] sz,
                                            input logic halfMode, input logic [31:0] d);
        logic [31:0] r;
        r = d;
        if (en) begin
            case (sz)
                SZ_WORD: begin
                    if (halfMode) begin
                        r = {d[15:0], d[31:16]};
                    end else begin
                        r = {d[7:0], d[15:8], d[23:16], d[31:24]};
                    end
                end
                SZ_HALF: r = {16'h0000, d[15:0]};
                SZ_BYTE: r = {24'h000000, d[7:0]};
                default: r = d;
            endcase
        end
        return r;
    endfunction : steer32

    function automatic logic [15:0] steer16(input logic byteSw, input logic [15:0] d);
        return byteSw ? {d[7:0], d[15:8]} : d;
    endfunction : steer16

    logic        dspEn;
    logic        dspHalfMode;
    logic        hostByteSw;
    logic        hostHalfSw;
    logic        take;
    logic        drain;
    logic [31:0] dspSteered;

    assign dspEn       = cur.ctrl[CTRL_DSP_EN];
    assign dspHalfMode = dspOddHalf || !dspByteNword;
    assign hostByteSw  = hostMemRegion ? cur.ctrl[CTRL_MEM_BYTE]
                                       : cur.ctrl[CTRL_REG_BYTE];
    assign hostHalfSw  = hostMemRegion ? cur.ctrl[CTRL_MEM_HALF]
                                       : cur.ctrl[CTRL_REG_HALF];
    assign dspSteered  = steer32(dspEn, dspSize, dspHalfMode, dspWdata);
    // Same condition the requester sees, so no word is taken while ready is low
    assign take        = dspValid && dspReady;
    assign drain       = cur.v0 && memReady;

    // Read answers need the request's mode; one copy, latched from the last read taken
    logic       rdHalfMode;
    logic [1:0] rdSize;
    logic       rdEn;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdHalfMode <= 1'b0;
            rdSize     <= 2'h0;
            rdEn       <= 1'b0;
        end else if (take && !dspWrite) begin
            rdHalfMode <= dspHalfMode;
            rdSize     <= dspSize;
            rdEn       <= dspEn;
        end
    end

    always_comb begin
        next_cur          = cur;
        next_cur.cfgRdata = 32'h00000000;
        if (cfgWrite && cfgAddr == ADDR_CTRL) begin
            next_cur.ctrl = cfgWdata[4:0];
        end
        if (cfgRead) begin
            case (cfgAddr)
                ADDR_CTRL:   next_cur.cfgRdata = {27'h0000000, cur.ctrl};
                ADDR_STATUS: next_cur.cfgRdata = {29'h00000000, cur.hostUpperSeen, cur.v1, cur.v0};
                default:     next_cur.cfgRdata = 32'h00000000;
            endcase
        end
        // Two-entry buffer toward memory: a stall there loses no word
        if (drain) begin
            next_cur.e0 = cur.e1;
            next_cur.v0 = cur.v1;
            next_cur.v1 = 1'b0;
        end
        if (take) begin
            if (!next_cur.v0) begin
                next_cur.e0 = '{dspWrite, dspSize, dspSteered};
                next_cur.v0 = 1'b1;
            end else begin
                next_cur.e1 = '{dspWrite, dspSize, dspSteered};
                next_cur.v1 = 1'b1;
            end
        end
        next_cur.rdValid = memRvalid;
        next_cur.rdData  = steer32(rdEn, rdSize, rdHalfMode, memRdata);
        // Host port: 32-bit values arrive as two halves; beats pass in arrival order
        if (hostValid && dspPortReady) begin
            if (hostWide) begin
                next_cur.hostUpperSeen = !hostUpper;
            end
            next_cur.hostRdata = steer16(hostByteSw, dspPortRdata);
        end
        next_cur.hostHeld = steer16(hostByteSw, hostWdata);
    end

    // Halfword exchange on the host port flips hostBeatHi, which leaves port data unchanged
    logic hostBeatHi;
    assign hostBeatHi = hostWide && (hostUpper ^ hostHalfSw);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur      <= '0;
            cur.ctrl <= CTRL_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // Host path beat is forwarded registered; hostBeatHi is registered but selects nothing
    logic        portValid;
    logic        portWrite;
    logic [15:0] portData;
    logic        portHi;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            portValid <= 1'b0;
            portWrite <= 1'b0;
            portData  <= 16'h0000;
            portHi    <= 1'b0;
        end else if (!portValid || dspPortReady) begin
            portValid <= hostValid;
            portWrite <= hostWrite;
            portData  <= steer16(hostByteSw, hostWdata);
            portHi    <= hostBeatHi;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dspReady <= 1'b0;
        end else begin
            dspReady <= !next_cur.v1;
        end
    end

    assign cfgRdata     = cur.cfgRdata;
    assign memValid     = cur.v0;
    assign memWrite     = cur.e0.write;
    assign memSize      = cur.e0.size;
    assign memWdata     = cur.e0.data;
    assign dspRvalid    = cur.rdValid;
    assign dspRdata     = cur.rdData;
    assign hostReady    = !portValid || dspPortReady;
    assign hostRdata    = cur.hostRdata;
    assign dspPortValid = portValid;
    assign dspPortWrite = portWrite;
    assign dspPortWdata = portHi ? portData : portData;
endmodule : endian_swap_steering
`default_nettype wire

// ### tb/endian_swap_properties.sv
// Port checks for the endian steering bridge.
// Bound to endian_swap_steering; mirrors CTRL from config writes.
`timescale 1ns/1ps
`default_nettype none
module endian_swap_properties (
    input wire logic                          clk, resetn, cfgWrite, cfgRead,
    input wire logic                          dspValid, dspReady, dspWrite, dspOddHalf,
    input wire logic                          dspByteNword, dspRvalid, memValid, memReady,
    input wire logic                          memRvalid, hostValid, hostReady, hostWrite,
    input wire logic                          hostMemRegion, hostWide, dspPortValid,
    input wire logic [3:0]                    cfgAddr,
    input wire logic [31:0]                   cfgWdata, cfgRdata, dspWdata, memWdata,
    input wire logic [1:0]                    memSize,
    input wire endian_swap_pkg::access_size_t dspSize,
    input wire logic [15:0]                   hostWdata, dspPortWdata
);
    import endian_swap_pkg::*;
    logic [4:0]  ctrl;
    logic        wTake, hm;
    logic [31:0] d, rev, hsw;
    logic [15:0] expH;
    // An empty buffer puts the new word at the head next cycle; so does one whose only word drains
    assign wTake = dspValid && dspReady && dspWrite && dspSize == SZ_WORD && !memValid;
    assign hm = dspOddHalf || !dspByteNword;
    assign d = dspWdata;
    assign rev = {d[7:0], d[15:8], d[23:16], d[31:24]};
    assign hsw = {d[15:0], d[31:16]};
    assign expH = (hostMemRegion ? ctrl[CTRL_MEM_BYTE] : ctrl[CTRL_REG_BYTE]) ?
                  {hostWdata[7:0], hostWdata[15:8]} : hostWdata;
    always_ff @(posedge clk or negedge resetn)
        if (!resetn) ctrl <= CTRL_RESET;
        else if (cfgWrite && cfgAddr == ADDR_CTRL) ctrl <= cfgWdata[4:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_idle; !$past(cfgRead) |-> cfgRdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_ctrl; cfgRead && cfgAddr == ADDR_CTRL |=> cfgRdata == {27'h0, $past(ctrl)}; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
    property p_bypass; wTake && !ctrl[0] |=> memValid && memWdata == $past(d) && memSize == 2'h2;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass word altered");
    property p_byterev; wTake && ctrl[0] && !hm |=> memWdata == $past(rev); endproperty
    a_byterev: assert property (p_byterev) else $error("bytes not reversed");
    property p_halfx; wTake && ctrl[0] && hm |=> memWdata == $past(hsw); endproperty
    a_halfx: assert property (p_halfx) else $error("halves not exchanged");
    property p_hold; memValid && !memReady |=> memValid && $stable(memWdata); endproperty
    a_hold: assert property (p_hold) else $error("stalled word lost");
    property p_rsp; memRvalid |=> dspRvalid; endproperty
    a_rsp: assert property (p_rsp) else $error("read answer late");
    property p_host; hostValid && hostReady && hostWrite && !hostWide
        |=> dspPortValid && dspPortWdata == $past(expH); endproperty
    a_host: assert property (p_host) else $error("host beat steered wrongly");
    c_full: cover property (memValid && !memReady && !dspReady);
    c_half: cover property (wTake && ctrl[0] && hm);
    c_host: cover property (hostValid && hostReady && hostMemRegion);
endmodule : endian_swap_properties
`default_nettype wire

// ### tb/far_side_model.sv
// Far side: one-word system memory and the DSP end of the host port.
// Memory accepts unless stalled and answers reads one cycle later.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input  wire logic        clk, resetn, stall, memValid, memWrite,
    input  wire logic        dspPortValid, dspPortWrite,
    input  wire logic [31:0] memWdata,
    input  wire logic [15:0] dspPortWdata,
    output var  logic        memReady, memRvalid, dspPortReady,
    output var  logic [31:0] memRdata, store,
    output var  logic [15:0] dspPortRdata, portStore,
    output var  logic [7:0]  nWrites
);
    assign memReady = !stall;
    assign dspPortReady = 1'b1;
    // Idle read bus shows the inverse, so a stale copy never passes
    assign memRdata = memRvalid ? store : ~store;
    assign dspPortRdata = ~portStore;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            memRvalid <= 1'b0;
            store <= 32'h0;
            portStore <= 16'h0;
            nWrites <= 8'h0;
        end else begin
            memRvalid <= memValid && memReady && !memWrite;
            if (memValid && memReady && memWrite) begin
                store <= memWdata;
                nWrites <= nWrites + 8'h1;
            end
            if (dspPortValid && dspPortWrite) portStore <= dspPortWdata;
        end
    end
endmodule : far_side_model
`default_nettype wire

// ### tb/test_endian_swap_steering.sv
// Self-checking bench for the endian steering bridge.
// Needs endian_swap_pkg, far_side_model and endian_swap_properties.
`timescale 1ns/1ps
`default_nettype none
bind endian_swap_steering endian_swap_properties u_props (.*);
module test_endian_swap_steering;
    import endian_swap_pkg::*;
    logic         clk = 1'b0, resetn = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0, stall = 1'b0;
    logic         dspValid = 1'b0, dspWrite = 1'b0, dspOddHalf = 1'b0, dspByteNword = 1'b1;
    logic         hostValid = 1'b0, hostWrite = 1'b0, hostMemRegion = 1'b0;
    logic         hostWide = 1'b0, hostUpper = 1'b0;
    logic [3:0]   cfgAddr = 4'h0;
    logic [31:0]  cfgWdata = 32'h0, dspWdata = 32'h0, cfgRdata, dspRdata, memWdata, memRdata, store;
    logic [15:0]  hostWdata = 16'h0, hostRdata, dspPortWdata, dspPortRdata, portStore;
    logic         dspReady, dspRvalid, memValid, memReady, memWrite, memRvalid, hostReady;
    logic         dspPortValid, dspPortReady, dspPortWrite;
    logic [1:0]   memSize;
    logic [7:0]   nWrites;
    access_size_t dspSize = SZ_WORD;
    int           n_fail = 0, n_checks = 0;
    endian_swap_steering DUT (.*);
    far_side_model u_far (.*);
    initial forever #4 clk = ~clk;
    task automatic check(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic waitHi(ref logic s);
        for (int i = 0; i < 64 && s !== 1'b1; i++) @(negedge clk);
        if (s !== 1'b1) begin
            n_fail++;
            conclude();
        end
    endtask : waitHi
    task automatic cfgWr(input logic [3:0] a, input logic [31:0] v);
        cfgAddr <= a;
        cfgWdata <= v;
        cfgWrite <= 1'b1;
        @(posedge clk);
        cfgWrite <= 1'b0;
    endtask : cfgWr
    task automatic cfgRd(input logic [3:0] a, output logic [31:0] q);
        cfgAddr <= a;
        cfgRead <= 1'b1;
        @(posedge clk);
        cfgRead <= 1'b0;
        @(negedge clk);
        q = cfgRdata;
        @(posedge clk);
    endtask : cfgRd
    task automatic dsp(input logic w, access_size_t s, logic o, b, logic [31:0] v);
        dspValid <= 1'b1;
        dspWrite <= w;
        dspSize <= s;
        dspOddHalf <= o;
        dspByteNword <= b;
        dspWdata <= v;
        @(negedge clk);
        waitHi(dspReady);
        @(posedge clk);
        dspValid <= 1'b0;
    endtask : dsp
    task automatic rd(input logic o, b, output logic [31:0] q);
        dsp(1'b0, SZ_WORD, o, b, 32'h0);
        waitHi(dspRvalid);
        q = dspRdata;
        @(posedge clk);
    endtask : rd
    task automatic host(input logic r, logic [15:0] v);
        @(posedge clk);
        hostValid <= 1'b1;
        hostWrite <= 1'b1;
        hostMemRegion <= r;
        hostWdata <= v;
        @(negedge clk);
        waitHi(hostReady);
        @(posedge clk);
        hostValid <= 1'b0;
        waitHi(dspPortValid);
        @(negedge clk);
    endtask : host
    task automatic tReset();
        logic [31:0] q;
        cfgRd(ADDR_CTRL, q);
        check(q, {27'h0, CTRL_RESET});
        cfgRd(4'h8, q);
        check(q, 32'h0);
        $display("reset test done");
    endtask : tReset
    task automatic tWord();
        logic [31:0] q, v;
        // Mode 0 bypass, 1 byte reversal, 2 odd halfword, 3 halfword select low
        for (int m = 0; m < 4; m++) begin
            cfgWr(ADDR_CTRL, {31'h0, m != 0} | 32'h14);
            v = (m < 2) ? 32'hDDCCBBAA : 32'hCCDDAABB;
            dsp(1'b1, SZ_WORD, m == 2, m != 3, v);
            rd(m == 2, m != 3, q);
            check(store, m == 0 ? v : 32'hAABBCCDD);
            check(q, v);
        end
        $display("word test done");
    endtask : tWord
    task automatic tByte();
        logic [31:0] q;
        dsp(1'b1, SZ_BYTE, 1'b0, 1'b1, 32'h5A);
        rd(1'b0, 1'b1, q);
        check({24'h0, store[7:0]}, 32'h5A);
        check(q, 32'h5A000000);
        $display("byte test done");
    endtask : tByte
    task automatic tStall();
        logic [31:0] q;
        logic [7:0]  n0;
        n0 = nWrites;
        stall <= 1'b1;
        dsp(1'b1, SZ_WORD, 1'b0, 1'b1, 32'h11223344);
        @(posedge clk);
        dsp(1'b1, SZ_WORD, 1'b0, 1'b1, 32'h55667788);
        @(negedge clk);
        check({31'h0, dspReady}, 32'h0);
        @(posedge clk);
        stall <= 1'b0;
        rd(1'b0, 1'b1, q);
        check({24'h0, nWrites - n0}, 32'h2);
        check(store, 32'h88776655);
        $display("stall test done");
    endtask : tStall
    task automatic tHost();
        cfgWr(ADDR_CTRL, 32'h1C);
        host(1'b0, 16'h1234);
        check({16'h0, portStore}, 32'h3412);
        host(1'b1, 16'h1234);
        check({16'h0, portStore}, 32'h1234);
        $display("host test done");
    endtask : tHost
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        tReset();
        tWord();
        tByte();
        tStall();
        tHost();
        conclude();
    end
endmodule : test_endian_swap_steering
`default_nettype wire
